// ---- core/link_gate.sv ----
// Transmit gating, receive qualification, reset sequencing and lane/channel status of the link layer.
`timescale 1ns/1ps
module link_gate
  import link_gate_pkg::*;
#(
  parameter int DATA_W       = 64,
  parameter int VERIFY_COUNT = VERIFY_NEEDED,
  parameter int INIT_PERIOD  = INIT_PERIOD_CYC
) (
  input  wire logic              CLOCK_I,
  input  wire logic              SYS_RST_I,
  input  wire logic              TX_RESET_I,
  input  wire logic              RX_RESET_I,
  input  wire logic              CLK_NOT_LOCKED_I,
  input  wire logic              NFC_ENABLE_I,
  input  wire logic              SIMPLEX_RECOVER_I,
  input  wire logic              NFC_REQ_I,
  input  wire logic              UFC_REQ_I,
  input  wire logic              USER_K_VALID_I,
  input  wire logic              TX_VALID_I,
  output logic                   TX_READY_O,
  output logic                   TX_ACCEPT_O,
  input  wire logic              REMOTE_XOFF_I,
  input  wire logic              REMOTE_XON_I,
  input  wire logic              BLOCK_SYNC_I,
  input  wire logic              TRAIN_DONE_I,
  input  wire logic              VERIFY_RX_I,
  input  wire logic              LINE_VALID_I,
  input  wire logic              LINE_LAST_I,
  input  wire logic [DATA_W-1:0] LINE_DATA_I,
  output logic                   RX_VALID_O,
  output logic                   RX_LAST_O,
  output logic [DATA_W-1:0]      RX_DATA_O,
  output logic                   TX_RESET_DONE_O,
  output logic                   RX_RESET_DONE_O,
  output logic                   SEND_INIT_O,
  output logic                   LANE_UP_O,
  output logic                   CHANNEL_UP_O
);
  // every register here runs on CLOCK_I, the clock derived from the transmit output clock.

  typedef enum logic [3:0] {
    ST_HOLD = 4'h1,
    ST_TX   = 4'h2,
    ST_RX   = 4'h4,
    ST_DONE = 4'h8
  } rst_state_e;

  rst_state_e   state;
  rst_state_e   next_state;
  logic         xoff;
  logic [2:0]   verify_cnt;
  logic [$clog2(INIT_PERIOD+1)-1:0] init_cnt;
  logic         tx_stage_done;
  logic         rx_stage_done;
  logic [1:0]   stage_done;

  // Any hold condition keeps the sequencer in its first state.
  wire hold_any = CLK_NOT_LOCKED_I | TX_RESET_I | RX_RESET_I;

  // Stage counters time each transceiver reset step.
  stage_counter #(.COUNT(STAGE_HOLD_CYC)) u_tx_stage (
    .CLOCK_I   (CLOCK_I),
    .SYS_RST_I (SYS_RST_I),
    .start_i   (state == ST_TX),
    .done_o    (tx_stage_done)
  );
  stage_counter #(.COUNT(STAGE_HOLD_CYC)) u_rx_stage (
    .CLOCK_I   (CLOCK_I),
    .SYS_RST_I (SYS_RST_I),
    .start_i   (state == ST_RX),
    .done_o    (rx_stage_done)
  );
  assign stage_done = {rx_stage_done, tx_stage_done};

  // Next-state decode of the sequential reset.
  always_comb
  begin
    next_state = state;
    case (state)
      ST_HOLD: if (!hold_any) next_state = ST_TX;
      ST_TX:   if (stage_done[TX_DONE_BIT]) next_state = ST_RX;
      ST_RX:   if (stage_done[RX_DONE_BIT]) next_state = ST_DONE;
      ST_DONE: next_state = ST_DONE;
      default: next_state = ST_HOLD;
    endcase
    if (hold_any)
      next_state = ST_HOLD;
  end

  // Reset sequencer state register.
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
      state <= ST_HOLD;
    else
      state <= next_state;
  end

  // Done indications: transmit after its stage, receive at the end of initialization.
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      TX_RESET_DONE_O <= 1'b0;
      RX_RESET_DONE_O <= 1'b0;
    end
    else
    begin
      TX_RESET_DONE_O <= (next_state == ST_RX) || (next_state == ST_DONE);
      RX_RESET_DONE_O <= (next_state == ST_DONE);
    end
  end

  wire init_done = (state == ST_DONE) & RX_RESET_DONE_O;

  // Next lane level, shared so that channel status never outlives the lane by a cycle.
  wire next_lane_up = init_done & BLOCK_SYNC_I & TRAIN_DONE_I;

  // Lane ready follows block sync and finished training after initialization.
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
      LANE_UP_O <= 1'b0;
    else
      LANE_UP_O <= next_lane_up;
  end

  // Verification sequences are counted while the lane is up; channel ready at the count.
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      verify_cnt   <= VERIFY_RST;
      CHANNEL_UP_O <= 1'b0;
    end
    else if (!LANE_UP_O || !next_lane_up)
    begin
      verify_cnt   <= VERIFY_RST;
      CHANNEL_UP_O <= 1'b0;
    end
    else if (VERIFY_RX_I && !CHANNEL_UP_O)
    begin
      verify_cnt <= verify_cnt + 3'h1;
      if (verify_cnt == 3'(VERIFY_COUNT - 1))
        CHANNEL_UP_O <= 1'b1;
    end
  end

  // Remote flow state: stop sets, resume clears, stop wins when both arrive together.
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
      xoff <= 1'b0;
    else if (!NFC_ENABLE_I || !CHANNEL_UP_O)
      xoff <= 1'b0;
    else if (REMOTE_XOFF_I)
      xoff <= 1'b1;
    else if (REMOTE_XON_I)
      xoff <= 1'b0;
  end

  // Transmit ready gating; acceptance is valid and ready in the same cycle.
  assign TX_READY_O  = CHANNEL_UP_O & ~NFC_REQ_I & ~UFC_REQ_I & ~USER_K_VALID_I & ~xoff;
  assign TX_ACCEPT_O = TX_VALID_I & TX_READY_O;

  // Periodic initialization pattern strobe for simplex automatic recovery.
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      init_cnt    <= '0;
      SEND_INIT_O <= 1'b0;
    end
    else if (!SIMPLEX_RECOVER_I || !TX_RESET_DONE_O)
    begin
      init_cnt    <= '0;
      SEND_INIT_O <= 1'b0;
    end
    else if (init_cnt == ($bits(init_cnt))'(INIT_PERIOD - 1))
    begin
      init_cnt    <= '0;
      SEND_INIT_O <= 1'b1;
    end
    else
    begin
      init_cnt    <= init_cnt + ($bits(init_cnt))'(1);
      SEND_INIT_O <= 1'b0;
    end
  end

  // Receive outputs register the line and qualify it with valid while channel is up.
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      RX_VALID_O <= 1'b0;
      RX_LAST_O  <= 1'b0;
      RX_DATA_O  <= '0;
    end
    else
    begin
      RX_VALID_O <= LINE_VALID_I & CHANNEL_UP_O;
      if (LINE_VALID_I && CHANNEL_UP_O)
      begin
        RX_LAST_O <= LINE_LAST_I;
        RX_DATA_O <= LINE_DATA_I;
      end
    end
  end

  // Channel ready needs the four sequences counted after the lane came up.
  property p_chan_needs_lane;
    @(posedge CLOCK_I) disable iff (SYS_RST_I) CHANNEL_UP_O |-> LANE_UP_O;
  endproperty
  a_chan_needs_lane: assert property (p_chan_needs_lane) else $error("channel up without lane up");

  property p_chan_rise;
    @(posedge CLOCK_I) disable iff (SYS_RST_I) $rose(CHANNEL_UP_O) |-> $past(verify_cnt) == 3'(VERIFY_COUNT - 1);
  endproperty
  a_chan_rise: assert property (p_chan_rise) else $error("channel up before four sequences");

  property p_flow_req;
    @(posedge CLOCK_I) disable iff (SYS_RST_I) (NFC_REQ_I || UFC_REQ_I) |-> !TX_READY_O;
  endproperty
  a_flow_req: assert property (p_flow_req) else $error("ready high during flow request");

  property p_user_k;
    @(posedge CLOCK_I) disable iff (SYS_RST_I) USER_K_VALID_I |-> !TX_READY_O;
  endproperty
  a_user_k: assert property (p_user_k) else $error("ready high during control block");

  property p_xoff;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
      (NFC_ENABLE_I && CHANNEL_UP_O && REMOTE_XOFF_I) ##1 (NFC_ENABLE_I && CHANNEL_UP_O && !REMOTE_XON_I) |-> !TX_READY_O;
  endproperty
  a_xoff: assert property (p_xoff) else $error("ready high after stop-flow");

  property p_ready_chan;
    @(posedge CLOCK_I) disable iff (SYS_RST_I) !CHANNEL_UP_O |-> !TX_READY_O;
  endproperty
  a_ready_chan: assert property (p_ready_chan) else $error("ready high while channel down");

  property p_rx_valid;
    @(posedge CLOCK_I) disable iff (SYS_RST_I) RX_VALID_O |-> $past(LINE_VALID_I) && $past(CHANNEL_UP_O);
  endproperty
  a_rx_valid: assert property (p_rx_valid) else $error("receive valid without line word");

  property p_lane;
    @(posedge CLOCK_I) disable iff (SYS_RST_I) $rose(LANE_UP_O) |-> $past(TRAIN_DONE_I) && $past(BLOCK_SYNC_I);
  endproperty
  a_lane: assert property (p_lane) else $error("lane up without training");

  property p_hold;
    @(posedge CLOCK_I) disable iff (SYS_RST_I) hold_any |=> state == ST_HOLD && !TX_RESET_DONE_O;
  endproperty
  a_hold: assert property (p_hold) else $error("initialization proceeded while held");

  property p_order;
    @(posedge CLOCK_I) disable iff (SYS_RST_I) RX_RESET_DONE_O |-> TX_RESET_DONE_O;
  endproperty
  a_order: assert property (p_order) else $error("receive done before transmit done");

  property p_init;
    @(posedge CLOCK_I) disable iff (SYS_RST_I) SEND_INIT_O |=> !SEND_INIT_O;
  endproperty
  a_init: assert property (p_init) else $error("init strobe longer than one cycle");
endmodule

// ---- core/link_gate_pkg.sv ----
// Package of constants shared by the serial link transmit gating and status block.
package link_gate_pkg;
  // Clock period in picoseconds at 200 MHz.
  localparam int CLK_PERIOD_PS = 5000;
  // Number of verification sequences that must be received before the channel is ready.
  localparam int VERIFY_NEEDED = 4;
  // Time in nanoseconds that each transceiver reset stage is held, one stage after another.
  localparam int STAGE_HOLD_NS = 100;
  localparam int STAGE_HOLD_CYC = (STAGE_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Period of the periodic initialization pattern in simplex recovery, in nanoseconds.
  localparam int INIT_PERIOD_NS = 1000;
  localparam int INIT_PERIOD_CYC = (INIT_PERIOD_NS * 1000) / CLK_PERIOD_PS;
  // Reset value of the verification counter.
  localparam logic [2:0] VERIFY_RST = 3'h0;
  // Bit positions of the stage-done vector.
  localparam int TX_DONE_BIT = 0;
  localparam int RX_DONE_BIT = 1;
endpackage

// ---- core/stage_counter.sv ----
// Down counter that raises a done level after a fixed number of cycles once started.
`timescale 1ns/1ps
module stage_counter #(
  parameter int COUNT = 20
) (
  input  wire logic CLOCK_I,
  input  wire logic SYS_RST_I,
  input  wire logic start_i,
  output logic      done_o
);
  localparam int W = $clog2(COUNT + 1);
  logic [W-1:0] cnt;

  // Counter loads while start is low, counts down to zero once started, then holds done.
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      cnt    <= '0;
      done_o <= 1'b0;
    end
    else if (!start_i)
    begin
      cnt    <= W'(COUNT);
      done_o <= 1'b0;
    end
    else if (cnt != '0)
      cnt <= cnt - W'(1);
    else
      done_o <= 1'b1;
  end
endmodule

// ---- tb/link_partner.sv ----
// Far-end lane partner model: lane training and verification sequences.
`timescale 1ns/1ps
module link_partner (
  input  wire logic       CLOCK_I,
  input  wire logic       SYS_RST_I,
  input  wire logic       train_i,
  input  wire logic       lane_up_i,
  input  wire logic [2:0] verify_limit_i,
  output logic            block_sync_o,
  output logic            train_done_o,
  output logic            verify_o
);
  logic [2:0] sent;
  logic [1:0] gap;
  wire        send = lane_up_i && gap == 2'h3 && sent < verify_limit_i;
  // Sync, then training, then one sequence every fourth cycle up to the limit.
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      block_sync_o <= 1'h0;
      train_done_o <= 1'h0;
      verify_o     <= 1'h0;
      sent         <= 3'h0;
      gap          <= 2'h0;
    end
    else
    begin
      block_sync_o <= train_i;
      train_done_o <= block_sync_o & train_i;
      gap          <= gap + 2'h1;
      verify_o     <= send;
      if (!lane_up_i)
        sent <= 3'h0;
      else if (send)
        sent <= sent + 3'h1;
    end
  end
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the link gating and status block.
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'h0, rst = 1'h0, tx_rst = 1'h1, rx_rst = 1'h0, nlock = 1'h1;
  logic        nfc_en = 1'h1, recover = 1'h0, nfc = 1'h0, ufc = 1'h0, usr_k = 1'h0;
  logic        xoff = 1'h0, xon = 1'h0, train = 1'h0, l_v = 1'h0, l_l = 1'h0, tx_v = 1'h1;
  logic [63:0] l_d = 64'h0;
  logic [2:0]  vlim = 3'h3;
  wire         bsync, tdone, vrx, TX_READY_O, TX_ACCEPT_O, RX_VALID_O, RX_LAST_O;
  wire         TX_RESET_DONE_O, RX_RESET_DONE_O, SEND_INIT_O, LANE_UP_O, CHANNEL_UP_O;
  wire [63:0]  RX_DATA_O;
  wire [3:0]   st = {CHANNEL_UP_O, LANE_UP_O, RX_RESET_DONE_O, TX_RESET_DONE_O};
  int          mismatches = 0, compares = 0, seed = 70, inits = 0;
  logic [64:0] expq[$];

  // Clock for the fabric logic.
  always #2.5 clk = ~clk;

  link_gate #(.INIT_PERIOD(8)) uut (
    .CLOCK_I(clk), .SYS_RST_I(rst), .TX_RESET_I(tx_rst), .RX_RESET_I(rx_rst),
    .CLK_NOT_LOCKED_I(nlock), .NFC_ENABLE_I(nfc_en), .SIMPLEX_RECOVER_I(recover),
    .NFC_REQ_I(nfc), .UFC_REQ_I(ufc), .USER_K_VALID_I(usr_k), .TX_VALID_I(tx_v),
    .TX_READY_O(TX_READY_O), .TX_ACCEPT_O(TX_ACCEPT_O), .REMOTE_XOFF_I(xoff),
    .REMOTE_XON_I(xon), .BLOCK_SYNC_I(bsync), .TRAIN_DONE_I(tdone), .VERIFY_RX_I(vrx),
    .LINE_VALID_I(l_v), .LINE_LAST_I(l_l), .LINE_DATA_I(l_d), .RX_VALID_O(RX_VALID_O),
    .RX_LAST_O(RX_LAST_O), .RX_DATA_O(RX_DATA_O), .TX_RESET_DONE_O(TX_RESET_DONE_O),
    .RX_RESET_DONE_O(RX_RESET_DONE_O), .SEND_INIT_O(SEND_INIT_O), .LANE_UP_O(LANE_UP_O),
    .CHANNEL_UP_O(CHANNEL_UP_O));

  link_partner peer (
    .CLOCK_I(clk), .SYS_RST_I(rst), .train_i(train), .lane_up_i(LANE_UP_O),
    .verify_limit_i(vlim), .block_sync_o(bsync), .train_done_o(tdone), .verify_o(vrx));

  task automatic check(string what, logic [64:0] seen, logic [64:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("compares %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic nx(int n);
    repeat (n) @(negedge clk);
  endtask

  // Bounded wait for one status level; running out ends the run.
  task automatic wait_st(int sel);
    int n;
    n = 0;
    while (st[sel] !== 1'h1 && n < 400)
    begin
      nx(1);
      n++;
    end
    if (n == 400)
    begin
      mismatches++;
      summarize;
    end
  endtask

  // One-cycle stop (k=0) or resume (k=1) message from the partner.
  task automatic pulse(int k);
    @(posedge clk);
    if (k == 0)
      xoff <= 1'h1;
    else
      xon <= 1'h1;
    @(posedge clk);
    xoff <= 1'h0;
    xon  <= 1'h0;
  endtask

  // Receive monitor: every valid word must match the oldest expected note.
  always @(negedge clk)
  begin
    if (SEND_INIT_O === 1'h1)
      inits++;
    if (RX_VALID_O === 1'h1)
    begin
      if (expq.size() == 0)
        check("stray rx word", 65'h1, 65'h0);
      else
        check("rx word", {RX_LAST_O, RX_DATA_O}, expq.pop_front());
    end
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    summarize;
  end

  initial
  begin
    logic [31:0] v;
    logic [63:0] w;
    int          a;
    rst = 1'h1;
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    nx(40);
    check("tx done held", TX_RESET_DONE_O, 1'h0);
    @(posedge clk) tx_rst <= 1'h0;
    nx(40);
    check("tx done unlocked", TX_RESET_DONE_O, 1'h0);
    @(posedge clk) nlock <= 1'h0;
    wait_st(0);
    check("rx done first", RX_RESET_DONE_O, 1'h0);
    wait_st(1);
    nx(10);
    check("lane untrained", LANE_UP_O, 1'h0);
    $display("test reset sequence done");
    @(posedge clk) {train, l_v} <= 2'h3;
    wait_st(2);
    nx(40);
    check("channel at three", CHANNEL_UP_O, 1'h0);
    check("ready while down", TX_READY_O, 1'h0);
    @(posedge clk) {vlim, l_v} <= 4'h8;
    wait_st(3);
    $display("test bring up done");
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk) {usr_k, ufc, nfc} <= 3'h1 << i;
      nx(1);
      check("ready gated", {TX_READY_O, TX_ACCEPT_O}, 2'h0);
      @(posedge clk) {usr_k, ufc, nfc} <= 3'h0;
      nx(1);
      check("ready open", {TX_READY_O, TX_ACCEPT_O}, 2'h3);
      @(posedge clk) tx_v <= 1'h0;
      nx(1);
      check("accept idle", {TX_READY_O, TX_ACCEPT_O}, 2'h2);
      @(posedge clk) tx_v <= 1'h1;
    end
    pulse(0);
    nx(5);
    check("ready stopped", TX_READY_O, 1'h0);
    pulse(1);
    nx(1);
    check("ready resumed", TX_READY_O, 1'h1);
    @(posedge clk) nfc_en <= 1'h0;
    pulse(0);
    nx(2);
    check("stop ignored", TX_READY_O, 1'h1);
    $display("test transmit gating done");
    repeat (16)
    begin
      @(posedge clk);
      v = $random(seed);
      w = {$random(seed), $random(seed)};
      l_v <= v[0];
      l_l <= v[1];
      l_d <= w;
      if (v[0])
        expq.push_back({v[1], w});
    end
    @(posedge clk) l_v <= 1'h0;
    nx(3);
    check("rx words left", expq.size(), 0);
    a = inits;
    nx(16);
    check("init while off", inits - a, 0);
    @(posedge clk) recover <= 1'h1;
    nx(4);
    @(posedge clk) a = inits;
    repeat (32) @(posedge clk);
    check("init strobes", inits - a, 4);
    $display("test receive and recovery done");
    @(posedge clk) {rx_rst, tx_rst} <= 2'h3;
    nx(6);
    check("status held", {st, TX_READY_O}, 5'h0);
    $display("test hold done");
    summarize;
  end
endmodule
